// *** dv/tb.sv ***
`timescale 1ns/1ns
`include "tpc_params.svh"
module tb;
  logic clock, reset_n, psel, penable, pwrite, pready, pslverr, err, ch0_pin_a, osc_clk, cut_pin;
  logic pwm_out_en, half_period_toggle_out, adc_trigger, irq_request;
  logic [7:0] paddr, gen_cnt;
  logic [31:0] pwdata, prdata, rd, st, half, seed;
  logic [5:0] gates, snap;
  logic [31:0] width [6];
  logic [2:0] codes [7];
  int divs [7];
  int num_errors, compares, m, p, d;
  int adc_cnt = 0;
  int adc_base;
  int n [3];
  tpc_pwm_top tpc_pwm_top_i (.clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ch0_pin_a(ch0_pin_a), .fast_internal_oscillator_clock(osc_clk), .cutoff_or_irq_pin(cut_pin),
    .phase_one_normal_out(gates[0]), .phase_one_counter_out(gates[1]), .phase_two_normal_out(gates[2]),
    .phase_two_counter_out(gates[3]), .phase_three_normal_out(gates[4]), .phase_three_counter_out(gates[5]),
    .pwm_out_en(pwm_out_en), .half_period_toggle_out(half_period_toggle_out), .adc_trigger(adc_trigger),
    .irq_request(irq_request));
  tpc_gate_driver_model tpc_gate_driver_model_i (.clock(clock), .gate_in(gates), .drive_en(pwm_out_en),
    .toggle_in(half_period_toggle_out), .width_ff(width), .half_ff(half));
  // ====
  // Clock, external pin and oscillator stimulus
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  always @(posedge clock) begin
    gen_cnt <= (gen_cnt == 8'h0B) ? 8'h00 : gen_cnt + 8'h01;
    if (gen_cnt[1:0] == 2'h3) ch0_pin_a <= ~ch0_pin_a;
    if ((gen_cnt % 8'h03) == 8'h02) osc_clk <= ~osc_clk;
  end
  // Conversion trigger pulses seen at the pin
  always @(posedge clock) begin
    if (adc_trigger === 1'b1) adc_cnt <= adc_cnt + 1;
  end
  // ====
  // Helpers
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] act_w(int k, int dv);
    if (k % 2 == 0) return 32'(2 * (m - n[k / 2] - p + 1) * dv);
    return 32'(2 * (n[k / 2] + 1 - p) * dv);
  endfunction
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(logic wr, logic [7:0] a, logic [31:0] dat);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= dat;
    @(posedge clock);
    penable <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      @(posedge clock);
      if (pready === 1'b1) break;
    end
    check("pready", {31'h0, pready}, 32'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic report_and_stop();
    if (num_errors == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ====
  // Main sequence
  initial begin
    {psel, penable, pwrite, ch0_pin_a, osc_clk} = 5'h00;
    {paddr, gen_cnt, pwdata} = 48'h0;
    cut_pin = 1'b1;
    reset_n = 1'b0;
    seed = 32'hC446;
    num_errors = 0;
    compares = 0;
    codes = '{`TPC_CKS_DIV1, `TPC_CKS_DIV2, `TPC_CKS_DIV4, `TPC_CKS_DIV8, `TPC_CKS_DIV32, `TPC_CKS_EXT, `TPC_CKS_OSC};
    divs = '{1, 2, 4, 8, 32, 8, 6};
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    apb(1'b0, `TPC_ADDR_OUTCFG, 32'h0);
    check("outcfg_reset", rd, {13'h0, `TPC_OUTCFG_RESET});
    apb(1'b0, 8'h3C, 32'h0);
    check("unmapped_err", {31'h0, err}, 32'h1);
    check("unmapped_rd", rd, 32'h0);
    apb(1'b1, `TPC_ADDR_IRQEN, 32'h1F);
    for (int c = 0; c < 7; c++) begin
      d = divs[c];
      p = 1 + int'(xs() % 32'h4);
      m = 2 * p + 8 + int'(xs() % 32'hC);
      for (int k = 0; k < 3; k++) n[k] = p + int'(xs() % 32'(m - 2 * p + 1));
      if (c == 0) begin
        n[0] = p;
        n[2] = m - p;
      end
      apb(1'b1, `TPC_ADDR_CTRL0, {29'h0, codes[c]});
      apb(1'b1, `TPC_ADDR_CTRL1, {29'h0, codes[c]});
      apb(1'b1, `TPC_ADDR_DTC, 32'(p));
      apb(1'b1, `TPC_ADDR_SCC, 32'h0);
      apb(1'b1, `TPC_ADDR_PERIOD, 32'(m));
      apb(1'b1, `TPC_ADDR_CMP1, 32'(n[0]));
      apb(1'b1, `TPC_ADDR_CMP2, 32'(n[1]));
      apb(1'b1, `TPC_ADDR_CMP3, 32'(n[2]));
      for (int k = 0; k < 3; k++) apb(1'b1, `TPC_ADDR_BUF1 + 8'(4 * k), 32'(n[k]));
      apb(1'b1, `TPC_ADDR_OUTCFG, (c == 1) ? 32'h0007903F : 32'h0007103F);
      apb(1'b1, `TPC_ADDR_START, 32'h3);
      if (c == 0) apb(1'b1, `TPC_ADDR_PERIOD, 32'(m + 7));
      apb(1'b0, `TPC_ADDR_DTC, 32'h0);
      check("count_range", {31'h0, rd <= 32'(m)}, 32'h1);
      adc_base = adc_cnt;
      repeat (6 * (m + 2 - p) * d + 40) @(posedge clock);
      check("half_period", half, 32'((m + 2 - p) * d));
      for (int k = 0; k < 6; k++) check("gate_width", width[k], act_w(k, d));
      check("adc_pulses", {31'h0, (adc_cnt - adc_base) >= 3}, 32'h1);
      if (c == 1) begin
        apb(1'b1, `TPC_ADDR_BUF1, 32'(n[0] + 1));
        repeat (2 * (m + 2 - p) * d + 8) @(posedge clock);
        apb(1'b0, `TPC_ADDR_CMP1, 32'h0);
        check("buffer_xfer", rd, 32'(n[0] + 1));
      end
      apb(1'b1, `TPC_ADDR_START, 32'h4);
      repeat (3) @(posedge clock);
      snap = gates;
      apb(1'b0, `TPC_ADDR_DTC, 32'h0);
      st = rd;
      repeat (20) @(posedge clock);
      check("held_gates", {26'h0, gates}, {26'h0, snap});
      apb(1'b0, `TPC_ADDR_DTC, 32'h0);
      check("held_count", rd, st);
    end
    apb(1'b1, `TPC_ADDR_IRQEN, 32'h1);
    apb(1'b0, `TPC_ADDR_STATUS, 32'h0);
    check("flags_set", {27'h0, rd[4:0]}, 32'h1F);
    check("irq_on", {31'h0, irq_request}, 32'h1);
    apb(1'b1, `TPC_ADDR_STATUS, 32'h1F);
    apb(1'b1, `TPC_ADDR_STATUS, 32'h0);
    apb(1'b0, `TPC_ADDR_STATUS, 32'h0);
    check("flags_kept", {27'h0, rd[4:0]}, 32'h1F);
    apb(1'b1, `TPC_ADDR_STATUS, 32'h0);
    apb(1'b0, `TPC_ADDR_STATUS, 32'h0);
    check("flags_clear", {27'h0, rd[4:0]}, 32'h0);
    check("irq_off", {31'h0, irq_request}, 32'h0);
    check("drive_on", {31'h0, pwm_out_en}, 32'h1);
    cut_pin <= 1'b0;
    repeat (5) @(posedge clock);
    check("drive_cut", {31'h0, pwm_out_en}, 32'h0);
    report_and_stop();
  end
  initial begin
    #200000;
    num_errors++;
    report_and_stop();
  end
endmodule // tb

// *** dv/tpc_gate_driver_model.sv ***
`timescale 1ns/1ns
// ====
// Gate driver side: measures active widths and toggle spacing
module tpc_gate_driver_model (
  input wire logic clock, // System clock
  input wire logic [5:0] gate_in, // ph1n,ph1c,ph2n,ph2c,ph3n,ph3c
  input wire logic drive_en, // Timer drives the pins
  input wire logic toggle_in, // Half period toggle
  output logic [31:0] width_ff [6], // Last active width per gate
  output logic [31:0] half_ff // Last toggle spacing
);
  logic [31:0] run_ff [6];
  logic [31:0] tcnt_ff;
  logic prev_tog_ff;
  // Undriven pins count as inactive
  always_ff @(posedge clock) begin
    for (int i = 0; i < 6; i++) begin
      if (drive_en && gate_in[i]) begin
        run_ff[i] <= run_ff[i] + 32'h1;
      end else begin
        if (run_ff[i] != 32'h0) width_ff[i] <= run_ff[i];
        run_ff[i] <= 32'h0;
      end
    end
  end
  always_ff @(posedge clock) begin
    prev_tog_ff <= toggle_in;
    if (toggle_in != prev_tog_ff) begin
      half_ff <= tcnt_ff;
      tcnt_ff <= 32'h1;
    end else begin
      tcnt_ff <= tcnt_ff + 32'h1;
    end
  end
endmodule // tpc_gate_driver_model

// *** logic/tpc_count_clock.sv ***
`timescale 1ns/1ns
`include "tpc_params.svh"
module tpc_count_clock import tpc_pkg::*; (
  input wire logic clock, // 250 MHz system clock
  input wire logic reset_n, // Asynchronous reset
  input wire logic ch0_pin_a, // External count clock pin
  input wire logic fast_internal_oscillator_clock, // On-chip oscillator
  tpc_tick_if.gen cc // Count tick toward the counters
);
  // ==========================================
  // Synchronisers and prescaler
  logic [1:0] ext_sync_ff;
  logic [1:0] osc_sync_ff;
  logic ext_last_ff;
  logic osc_last_ff;
  logic [4:0] pre_ff;
  logic ext_edge;
  logic osc_edge;
  logic nxt_tick;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ext_sync_ff <= 2'h0;
      osc_sync_ff <= 2'h0;
      ext_last_ff <= 1'b0;
      osc_last_ff <= 1'b0;
    end else begin
      ext_sync_ff <= {ext_sync_ff[0], ch0_pin_a};
      osc_sync_ff <= {osc_sync_ff[0], fast_internal_oscillator_clock};
      ext_last_ff <= ext_sync_ff[1];
      osc_last_ff <= osc_sync_ff[1];
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pre_ff <= 5'h00;
    end else begin
      pre_ff <= pre_ff + 5'h01;
    end
  end

  // ==========================================
  // Count source select
  assign osc_edge = osc_sync_ff[1] & ~osc_last_ff;
  always_comb begin
    unique case (cc.edge_select)
      2'h0: ext_edge = ext_sync_ff[1] & ~ext_last_ff;
      2'h1: ext_edge = ~ext_sync_ff[1] & ext_last_ff;
      default: ext_edge = ext_sync_ff[1] ^ ext_last_ff;
    endcase
  end

  always_comb begin
    unique case (cc.clock_source_select)
      `TPC_CKS_DIV1: nxt_tick = 1'b1;
      `TPC_CKS_DIV2: nxt_tick = pre_ff[0];
      `TPC_CKS_DIV4: nxt_tick = &pre_ff[1:0];
      `TPC_CKS_DIV8: nxt_tick = &pre_ff[2:0];
      `TPC_CKS_DIV32: nxt_tick = &pre_ff;
      `TPC_CKS_EXT: nxt_tick = cc.ext_enable & ext_edge;
      `TPC_CKS_OSC: nxt_tick = osc_edge;
      default: nxt_tick = 1'b0;
    endcase
  end

  assign cc.count_tick = nxt_tick;
  assign cc.pin_a_level = ext_sync_ff[1];
endmodule // tpc_count_clock

// *** logic/tpc_params.svh ***
`ifndef TPC_PARAMS_SVH
`define TPC_PARAMS_SVH
// Register byte offsets on the bus
`define TPC_ADDR_START 8'h00
`define TPC_ADDR_CTRL0 8'h04
`define TPC_ADDR_CTRL1 8'h08
`define TPC_ADDR_DTC 8'h0C
`define TPC_ADDR_SCC 8'h10
`define TPC_ADDR_PERIOD 8'h14
`define TPC_ADDR_CMP1 8'h18
`define TPC_ADDR_CMP2 8'h1C
`define TPC_ADDR_CMP3 8'h20
`define TPC_ADDR_BUF1 8'h24
`define TPC_ADDR_BUF2 8'h28
`define TPC_ADDR_BUF3 8'h2C
`define TPC_ADDR_OUTCFG 8'h30
`define TPC_ADDR_STATUS 8'h34
`define TPC_ADDR_IRQEN 8'h38
// Start register fields
`define TPC_RUN0_BIT 0
`define TPC_RUN1_BIT 1
`define TPC_STOPSEL_BIT 2
// Output configuration fields
`define TPC_POL_LSB 0
`define TPC_INIT_LSB 6
`define TPC_OE_BIT 12
`define TPC_XFER_LSB 13
`define TPC_BUFEN_BIT 15
`define TPC_CUTEN_BIT 16
`define TPC_ADTRG_BIT 17
`define TPC_EXTEN_BIT 18
`define TPC_OUTCFG_RESET 19'h0003F
// Status and enable fields
`define TPC_FLAG_PERIOD 0
`define TPC_FLAG_UNDER 4
`define TPC_NFLAGS 5
// Control register fields
`define TPC_CKS_LSB 0
`define TPC_EDGE_LSB 3
// Count source codes
`define TPC_CKS_DIV1 3'h0
`define TPC_CKS_DIV2 3'h1
`define TPC_CKS_DIV4 3'h2
`define TPC_CKS_DIV8 3'h3
`define TPC_CKS_DIV32 3'h4
`define TPC_CKS_EXT 3'h5
`define TPC_CKS_OSC 3'h6
// Transfer timing codes
`define TPC_XFER_PEAK 2'h0
`define TPC_XFER_TROUGH 2'h1
`define TPC_XFER_BOTH 2'h2
`define TPC_CNT_ONES 16'hFFFF
`define TPC_CNT_ZERO 16'h0000
`endif

// *** logic/tpc_pkg.sv ***
package tpc_pkg;
  typedef enum logic [1:0] {tpc_idle, tpc_up, tpc_down} tpc_dir_t;
  typedef logic [15:0] tpc_word_t;
endpackage

// *** logic/tpc_pwm_top.sv ***
// Register access over APB and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`include "tpc_params.svh"
module tpc_pwm_top import tpc_pkg::*; (
  input wire logic clock, // 250 MHz system clock
  input wire logic reset_n, // Asynchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic ch0_pin_a, // External count clock pin
  input wire logic fast_internal_oscillator_clock, // On-chip oscillator input
  input wire logic cutoff_or_irq_pin, // Forced cutoff or interrupt pin
  output logic phase_one_normal_out, // Phase one normal output
  output logic phase_one_counter_out, // Phase one counter output
  output logic phase_two_normal_out, // Phase two normal output
  output logic phase_two_counter_out, // Phase two counter output
  output logic phase_three_normal_out, // Phase three normal output
  output logic phase_three_counter_out, // Phase three counter output
  output logic pwm_out_en, // Output enable for all six pins
  output logic half_period_toggle_out, // Toggles each half period
  output logic adc_trigger, // Conversion start pulse
  output logic irq_request // Interrupt request level
);
  // ==========================================
  // Declarations
  tpc_tick_if cc_if ();
  logic [2:0] start_ff;
  logic [4:0] ctrl0_ff;
  logic [4:0] ctrl1_ff;
  tpc_word_t dtc_ff;
  tpc_word_t scc_ff;
  tpc_word_t period_ff;
  tpc_word_t period_act_ff;
  tpc_word_t cmp_ff [3];
  tpc_word_t buf_ff [3];
  logic [18:0] outcfg_ff;
  logic [`TPC_NFLAGS-1:0] flag_ff;
  logic [`TPC_NFLAGS-1:0] seen_ff;
  logic [`TPC_NFLAGS-1:0] irqen_ff;
  tpc_dir_t dir_ff;
  logic started_ff;
  logic [5:0] lvl_ff;
  logic toggle_ff;
  logic adc_ff;
  logic [31:0] prdata_ff;
  logic [1:0] cut_sync_ff;
  logic running;
  logic tick;
  logic peak;
  logic trough;
  logic wr_en;
  logic rd_en;
  logic setup;
  logic mapped;
  logic xfer;
  logic [`TPC_NFLAGS-1:0] nxt_set;
  logic [5:0] nxt_lvl;
  logic [31:0] nxt_prdata;

  tpc_count_clock u_count_clock (
    .clock(clock),
    .reset_n(reset_n),
    .ch0_pin_a(ch0_pin_a),
    .fast_internal_oscillator_clock(fast_internal_oscillator_clock),
    .cc(cc_if.gen)
  );

  assign cc_if.clock_source_select = ctrl0_ff[`TPC_CKS_LSB +: 3];
  assign cc_if.edge_select = ctrl0_ff[`TPC_EDGE_LSB +: 2];
  assign cc_if.ext_enable = outcfg_ff[`TPC_EXTEN_BIT];
  assign running = start_ff[`TPC_RUN0_BIT] & start_ff[`TPC_RUN1_BIT];
  assign tick = running & cc_if.count_tick;
  assign peak = tick & (dir_ff == tpc_up) & (dtc_ff == period_act_ff);
  assign trough = tick & (dir_ff == tpc_down) & (scc_ff == `TPC_CNT_ZERO);

  // ==========================================
  // APB slave
  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;
  assign pready = psel & penable;
  assign mapped = (paddr[1:0] == 2'h0) && (paddr <= `TPC_ADDR_IRQEN);
  assign pslverr = pready & ~mapped;
  assign prdata = prdata_ff;

  always_comb begin
    nxt_prdata = 32'h0;
    unique case (paddr)
      `TPC_ADDR_START: nxt_prdata = {29'h0, start_ff};
      `TPC_ADDR_CTRL0: nxt_prdata = {27'h0, ctrl0_ff};
      `TPC_ADDR_CTRL1: nxt_prdata = {27'h0, ctrl1_ff};
      `TPC_ADDR_DTC: nxt_prdata = {16'h0, dtc_ff};
      `TPC_ADDR_SCC: nxt_prdata = {16'h0, scc_ff};
      `TPC_ADDR_PERIOD: nxt_prdata = {16'h0, period_ff};
      `TPC_ADDR_CMP1: nxt_prdata = {16'h0, cmp_ff[0]};
      `TPC_ADDR_CMP2: nxt_prdata = {16'h0, cmp_ff[1]};
      `TPC_ADDR_CMP3: nxt_prdata = {16'h0, cmp_ff[2]};
      `TPC_ADDR_BUF1: nxt_prdata = {16'h0, buf_ff[0]};
      `TPC_ADDR_BUF2: nxt_prdata = {16'h0, buf_ff[1]};
      `TPC_ADDR_BUF3: nxt_prdata = {16'h0, buf_ff[2]};
      `TPC_ADDR_OUTCFG: nxt_prdata = {13'h0, outcfg_ff};
      `TPC_ADDR_STATUS: nxt_prdata = {dir_ff == tpc_up, cc_if.pin_a_level, cut_sync_ff[1], 24'h0, flag_ff};
      `TPC_ADDR_IRQEN: nxt_prdata = {27'h0, irqen_ff};
      default: nxt_prdata = 32'h0;
    endcase
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      prdata_ff <= 32'h0;
    end else if (setup) begin
      prdata_ff <= nxt_prdata;
    end
  end

  // ==========================================
  // Configuration registers
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      start_ff <= 3'h0;
      ctrl0_ff <= 5'h00;
      ctrl1_ff <= 5'h00;
      outcfg_ff <= `TPC_OUTCFG_RESET;
      irqen_ff <= 5'h00;
    end else if (wr_en) begin
      unique case (paddr)
        `TPC_ADDR_START: begin
          start_ff[`TPC_STOPSEL_BIT] <= pwdata[`TPC_STOPSEL_BIT];
          if (pwdata[1:0] == 2'h3) begin
            start_ff[1:0] <= 2'h3;
          end else if (pwdata[`TPC_STOPSEL_BIT] && pwdata[1:0] == 2'h0) begin
            start_ff[1:0] <= 2'h0;
          end
        end
        `TPC_ADDR_CTRL0: ctrl0_ff <= pwdata[4:0];
        `TPC_ADDR_CTRL1: ctrl1_ff <= pwdata[4:0];
        `TPC_ADDR_OUTCFG: outcfg_ff <= pwdata[18:0];
        `TPC_ADDR_IRQEN: irqen_ff <= pwdata[4:0];
        default: ;
      endcase
    end
  end

  // ==========================================
  // Period register latched while stopped, compare registers with buffer transfer
  always_comb begin
    unique case (outcfg_ff[`TPC_XFER_LSB +: 2])
      `TPC_XFER_PEAK: xfer = peak;
      `TPC_XFER_TROUGH: xfer = trough;
      default: xfer = peak | trough;
    endcase
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      period_ff <= `TPC_CNT_ZERO;
      period_act_ff <= `TPC_CNT_ZERO;
    end else begin
      if (wr_en && paddr == `TPC_ADDR_PERIOD) begin
        period_ff <= pwdata[15:0];
      end
      if (!running) begin
        period_act_ff <= period_ff;
      end
    end
  end

  for (genvar i = 0; i < 3; i++) begin : g_cmp
    always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
        cmp_ff[i] <= `TPC_CNT_ZERO;
        buf_ff[i] <= `TPC_CNT_ZERO;
      end else begin
        if (wr_en && paddr == `TPC_ADDR_CMP1 + 8'(4 * i)) begin
          cmp_ff[i] <= pwdata[15:0];
        end else if (xfer && outcfg_ff[`TPC_BUFEN_BIT]) begin
          cmp_ff[i] <= buf_ff[i];
        end
        if (wr_en && paddr == `TPC_ADDR_BUF1 + 8'(4 * i)) begin
          buf_ff[i] <= pwdata[15:0];
        end
      end
    end
  end

  // ==========================================
  // Triangular carrier counters
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      dtc_ff <= `TPC_CNT_ZERO;
      scc_ff <= `TPC_CNT_ZERO;
      dir_ff <= tpc_idle;
    end else begin
      if (tick) begin
        if (dir_ff == tpc_down) begin
          dtc_ff <= dtc_ff - 16'h0001;
          scc_ff <= scc_ff - 16'h0001;
          dir_ff <= trough ? tpc_up : tpc_down;
        end else begin
          // Peak match takes one more count, so both slopes last period plus two minus dead time
          dtc_ff <= dtc_ff + 16'h0001;
          scc_ff <= scc_ff + 16'h0001;
          dir_ff <= peak ? tpc_down : tpc_up;
        end
      end
      if (wr_en && paddr == `TPC_ADDR_DTC) begin
        dtc_ff <= pwdata[15:0];
      end
      if (wr_en && paddr == `TPC_ADDR_SCC) begin
        scc_ff <= pwdata[15:0];
      end
      if (!running && !started_ff) begin
        dir_ff <= tpc_idle;
      end
    end
  end

  a_peak_turn: assert property (@(posedge clock) disable iff (!reset_n)
    peak && !(wr_en && paddr == `TPC_ADDR_DTC) |=> dir_ff == tpc_down && dtc_ff == $past(period_act_ff) + 16'h0001)
    else $error("counters did not turn down after the period value");
  a_trough_turn: assert property (@(posedge clock) disable iff (!reset_n)
    trough && !(wr_en && paddr == `TPC_ADDR_SCC) |=> dir_ff == tpc_up && scc_ff == `TPC_CNT_ONES)
    else $error("second counter did not wrap and turn up");
  a_period_fixed: assert property (@(posedge clock) disable iff (!reset_n)
    running && $past(running) |-> $stable(period_act_ff))
    else $error("active period changed while counting");

  // ==========================================
  // Output waveforms
  for (genvar i = 0; i < 3; i++) begin : g_phase
    logic normal_act;
    logic counter_act;
    logic [16:0] normal_edge;
    // Thresholds differ by one between slopes so widths come out even and both gaps equal the dead time
    assign normal_edge = {1'b0, cmp_ff[i]} + {1'b0, dtc_ff - scc_ff};
    assign normal_act = (dir_ff == tpc_down) ? ({1'b0, dtc_ff} > normal_edge) : ({1'b0, dtc_ff} >= normal_edge);
    assign counter_act = (dir_ff == tpc_down) ? (dtc_ff <= cmp_ff[i]) : (dtc_ff < cmp_ff[i]);
    assign nxt_lvl[2 * i] = normal_act ~^ outcfg_ff[`TPC_POL_LSB + 2 * i];
    assign nxt_lvl[2 * i + 1] = counter_act ~^ outcfg_ff[`TPC_POL_LSB + 2 * i + 1];
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      lvl_ff <= 6'h00;
      started_ff <= 1'b0;
    end else if (running) begin
      lvl_ff <= nxt_lvl;
      started_ff <= 1'b1;
    end else if (!started_ff) begin
      lvl_ff <= outcfg_ff[`TPC_INIT_LSB +: 6];
    end
  end

  a_stop_hold: assert property (@(posedge clock) disable iff (!reset_n)
    started_ff && !running |=> $stable(lvl_ff))
    else $error("outputs moved while stopped");

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cut_sync_ff <= 2'h3;
    end else begin
      cut_sync_ff <= {cut_sync_ff[0], cutoff_or_irq_pin};
    end
  end

  assign phase_one_normal_out = lvl_ff[0];
  assign phase_one_counter_out = lvl_ff[1];
  assign phase_two_normal_out = lvl_ff[2];
  assign phase_two_counter_out = lvl_ff[3];
  assign phase_three_normal_out = lvl_ff[4];
  assign phase_three_counter_out = lvl_ff[5];
  assign pwm_out_en = outcfg_ff[`TPC_OE_BIT] & ~(outcfg_ff[`TPC_CUTEN_BIT] & ~cut_sync_ff[1]);

  a_cutoff_off: assert property (@(posedge clock) disable iff (!reset_n)
    outcfg_ff[`TPC_CUTEN_BIT] && !cut_sync_ff[1] |-> !pwm_out_en)
    else $error("outputs enabled during forced cutoff");

  // ==========================================
  // Half period toggle and conversion trigger
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      toggle_ff <= 1'b0;
      adc_ff <= 1'b0;
    end else begin
      if (peak || trough) begin
        toggle_ff <= ~toggle_ff;
      end
      adc_ff <= peak & outcfg_ff[`TPC_ADTRG_BIT];
    end
  end

  assign half_period_toggle_out = toggle_ff;
  assign adc_trigger = adc_ff;

  a_toggle_half: assert property (@(posedge clock) disable iff (!reset_n)
    peak || trough |=> toggle_ff != $past(toggle_ff))
    else $error("toggle pin missed a half period");
  a_adc_pulse: assert property (@(posedge clock) disable iff (!reset_n)
    peak && outcfg_ff[`TPC_ADTRG_BIT] |=> adc_trigger ##1 !adc_trigger || peak)
    else $error("conversion trigger not a pulse at the peak");

  // ==========================================
  // Status flags and interrupt request
  for (genvar i = 0; i < 3; i++) begin : g_match
    assign nxt_set[i + 1] = tick & (dtc_ff == cmp_ff[i]);
  end
  assign nxt_set[`TPC_FLAG_PERIOD] = peak;
  assign nxt_set[`TPC_FLAG_UNDER] = trough;

  for (genvar i = 0; i < `TPC_NFLAGS; i++) begin : g_flag
    always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
        flag_ff[i] <= 1'b0;
        seen_ff[i] <= 1'b0;
      end else begin
        if (rd_en && paddr == `TPC_ADDR_STATUS) begin
          seen_ff[i] <= flag_ff[i];
        end else if (wr_en && paddr == `TPC_ADDR_STATUS) begin
          seen_ff[i] <= 1'b0;
        end
        if (nxt_set[i]) begin
          flag_ff[i] <= 1'b1;
        end else if (wr_en && paddr == `TPC_ADDR_STATUS && !pwdata[i] && seen_ff[i]) begin
          flag_ff[i] <= 1'b0;
        end
      end
    end
  end

  assign irq_request = |(flag_ff & irqen_ff);

  a_flag_clear: assert property (@(posedge clock) disable iff (!reset_n)
    wr_en && paddr == `TPC_ADDR_STATUS && !pwdata[0] && seen_ff[0] && !nxt_set[0] |=> !flag_ff[0])
    else $error("flag did not clear after read one, write zero");
  a_flag_keep: assert property (@(posedge clock) disable iff (!reset_n)
    flag_ff[1] && !seen_ff[1] |=> flag_ff[1])
    else $error("flag cleared without a prior read of one");
  a_irq_under: assert property (@(posedge clock) disable iff (!reset_n)
    trough && irqen_ff[`TPC_FLAG_UNDER] && !wr_en |=> irq_request)
    else $error("underflow raised no interrupt request");
endmodule // tpc_pwm_top

// *** logic/tpc_tick_if.sv ***
`timescale 1ns/1ns
interface tpc_tick_if;
  logic [2:0] clock_source_select;
  logic [1:0] edge_select;
  logic ext_enable;
  logic count_tick;
  logic pin_a_level;
  modport ctl (output clock_source_select, output edge_select, output ext_enable, input count_tick,
    input pin_a_level);
  modport gen (input clock_source_select, input edge_select, input ext_enable, output count_tick,
    output pin_a_level);
endinterface
